//--- logic/rfr_pkg.sv
// constants for the rail fault response select block
package rfr_pkg;
  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] RESP_CTRL_ADDR = 8'hB3;
  localparam logic [7:0] RESP_CTRL_RESET = 8'h00;
  localparam logic [7:0] FAULT_STAT_ADDR = 8'hD3;
  localparam logic [7:0] FAULT_STAT_RESET = 8'h00;
  localparam logic [7:0] UNMAPPED_RDATA = 8'h00;

  // ----------------------------------------------------------------
  // fault sources, field layout and status positions
  // ----------------------------------------------------------------
  localparam int NUM_FAULTS = 4;
  localparam int FIELD_W = 2;
  // source order: driver ov, driver uv, core ov, core uv
  localparam int FLD_DRV_OV = 0;
  localparam int FLD_DRV_UV = 2;
  localparam int FLD_CORE_OV = 4;
  localparam int FLD_CORE_UV = 6;
  localparam int STAT_DRV_OV = 2;
  localparam int STAT_DRV_UV = 3;
  localparam int STAT_CORE_OV = 0;
  localparam int STAT_CORE_UV = 1;

  // ----------------------------------------------------------------
  // response codes
  // ----------------------------------------------------------------
  localparam logic [1:0] RESP_FLAG = 2'h0;
  localparam logic [1:0] RESP_HICCUP = 2'h1;
  localparam logic [1:0] RESP_LATCH = 2'h2;
  localparam logic [1:0] RESP_FLAG_ALT = 2'h3;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam longint CLK_HZ = 100000000;
  localparam longint HICCUP_DELAY_MS = 500;
  localparam longint HICCUP_CYCLES = (HICCUP_DELAY_MS * CLK_HZ) / 1000;
  localparam int HIC_CNT_W = 27;

  typedef enum logic [2:0] {
    HIC_IDLE = 3'h1,
    HIC_HOLD = 3'h2,
    HIC_COUNT = 3'h4
  } rfr_hic_type;
endpackage : rfr_pkg

//--- logic/rfr_top.sv
// rail fault response select register and fault response logic
// Operation
// - response control register is one byte, read/write, reset to zero
// - global enable high uses register fields, low uses mode pin response
// - codes 00 and 11 only flag the fault; switching continues
// - code 01 stops switching, restarts fixed delay after fault clears
// - code 10 stops switching until switching or chip enable toggles
// - bits 1:0 drive driver rail overvoltage; sets status bit 2
// - bits 3:2 drive driver rail undervoltage; sets status bit 3
// - bits 5:4 drive core rail overvoltage; sets status bit 0
// - any fault sets its status bit and pulls fault flag low
// - bits 7:6 drive core rail undervoltage; sets status bit 1
module rfr_top #(
  parameter int HICCUP_CYCLES = int'(rfr_pkg::HICCUP_CYCLES)
) (
  input wire logic i_core_clk,
  input wire logic i_rst_b,
  input wire logic i_reg_wr,
  input wire logic [7:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  output logic [7:0] o_reg_rdata,
  input wire logic i_resp_en,
  input wire logic [1:0] i_mode_pin_resp,
  input wire logic i_driver_rail_ov,
  input wire logic i_driver_rail_uv,
  input wire logic i_core_rail_ov,
  input wire logic i_core_rail_uv,
  input wire logic i_pwm_en,
  input wire logic i_chip_en,
  output logic o_pwm_stop,
  output logic o_fault_flag_n_out,
  output logic o_fault_flag_n_oe
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] stat;
    logic [7:0] rdata;
    logic latched;
    rfr_pkg::rfr_hic_type hic;
    logic [rfr_pkg::HIC_CNT_W-1:0] cnt;
  } rfr_state_type;

  rfr_state_type state_q;
  rfr_state_type state_d;

  logic [rfr_pkg::NUM_FAULTS-1:0] fault;
  logic [rfr_pkg::NUM_FAULTS-1:0] hic_fault;
  logic [rfr_pkg::NUM_FAULTS-1:0] latch_fault;
  logic [1:0] resp [rfr_pkg::NUM_FAULTS];
  logic [7:0] stat_set;
  logic [7:0] stat_next;
  logic [rfr_pkg::HIC_CNT_W-1:0] hic_load;

  assign hic_load = rfr_pkg::HIC_CNT_W'(HICCUP_CYCLES - 1);

  // ----------------------------------------------------------------
  // per-source response decode
  // ----------------------------------------------------------------
  always_comb begin
    fault = {i_core_rail_uv, i_core_rail_ov, i_driver_rail_uv, i_driver_rail_ov};
    resp[0] = state_q.ctrl[rfr_pkg::FLD_DRV_OV +: rfr_pkg::FIELD_W];
    resp[1] = state_q.ctrl[rfr_pkg::FLD_DRV_UV +: rfr_pkg::FIELD_W];
    resp[2] = state_q.ctrl[rfr_pkg::FLD_CORE_OV +: rfr_pkg::FIELD_W];
    resp[3] = state_q.ctrl[rfr_pkg::FLD_CORE_UV +: rfr_pkg::FIELD_W];
    stat_set = 8'h00;
    stat_set[rfr_pkg::STAT_DRV_OV] = fault[0];
    stat_set[rfr_pkg::STAT_DRV_UV] = fault[1];
    stat_set[rfr_pkg::STAT_CORE_OV] = fault[2];
    stat_set[rfr_pkg::STAT_CORE_UV] = fault[3];
  end

  // ----------------------------------------------------------------
  // per-source action
  // ----------------------------------------------------------------
  for (genvar g = 0; g < rfr_pkg::NUM_FAULTS; g++) begin : g_src
    rfr_src_decode #(
      .FIELD_W(rfr_pkg::FIELD_W)
    ) decode_u (
      .i_fault(fault[g]),
      .i_resp_en(i_resp_en),
      .i_field(resp[g]),
      .i_mode_pin_resp(i_mode_pin_resp),
      .o_hic(hic_fault[g]),
      .o_latch(latch_fault[g])
    );
  end

  // ----------------------------------------------------------------
  // status: write one to clear, sticky set
  // ----------------------------------------------------------------
  rfr_sticky_next #(
    .W(8)
  ) sticky_u (
    .i_q(state_q.stat),
    .i_clr_en(i_reg_wr && (i_reg_addr == rfr_pkg::FAULT_STAT_ADDR)),
    .i_clr_mask(i_reg_wdata),
    .i_set(stat_set),
    .o_d(stat_next)
  );

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    // register writes
    if (i_reg_wr && (i_reg_addr == rfr_pkg::RESP_CTRL_ADDR)) begin
      state_d.ctrl = i_reg_wdata;
    end
    state_d.stat = stat_next;
    // registered read data
    case (i_reg_addr)
      rfr_pkg::RESP_CTRL_ADDR: state_d.rdata = state_q.ctrl;
      rfr_pkg::FAULT_STAT_ADDR: state_d.rdata = state_q.stat;
      default: state_d.rdata = rfr_pkg::UNMAPPED_RDATA;
    endcase
    // latch-off, released only while an enable is low; a held fault re-latches
    if (!i_pwm_en || !i_chip_en) begin
      state_d.latched = 1'b0;
    end
    if (|latch_fault) begin
      state_d.latched = 1'b1;
    end
    // hiccup timer shared by all sources: the last fault to clear restarts it
    case (state_q.hic)
      rfr_pkg::HIC_IDLE: begin
        if (|hic_fault) begin
          state_d.hic = rfr_pkg::HIC_HOLD;
        end
      end
      rfr_pkg::HIC_HOLD: begin
        if (!(|hic_fault)) begin
          state_d.hic = rfr_pkg::HIC_COUNT;
          state_d.cnt = hic_load;
        end
      end
      rfr_pkg::HIC_COUNT: begin
        if (|hic_fault) begin
          state_d.hic = rfr_pkg::HIC_HOLD;
        end else if (state_q.cnt == '0) begin
          state_d.hic = rfr_pkg::HIC_IDLE;
        end else begin
          state_d.cnt = state_q.cnt - 1'b1;
        end
      end
      default: begin
        state_d.hic = rfr_pkg::HIC_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_q.ctrl <= rfr_pkg::RESP_CTRL_RESET;
      state_q.stat <= rfr_pkg::FAULT_STAT_RESET;
      state_q.rdata <= rfr_pkg::UNMAPPED_RDATA;
      state_q.latched <= 1'b0;
      state_q.hic <= rfr_pkg::HIC_IDLE;
      state_q.cnt <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign o_reg_rdata = state_q.rdata;
  assign o_pwm_stop = state_q.latched || (state_q.hic != rfr_pkg::HIC_IDLE);
  assign o_fault_flag_n_out = 1'b0;
  assign o_fault_flag_n_oe = |state_q.stat;
endmodule : rfr_top

// ----------------------------------------------------------------
// one fault source: selected code and the action it asks for
// ----------------------------------------------------------------
module rfr_src_decode #(
  parameter int FIELD_W = rfr_pkg::FIELD_W
) (
  input wire logic i_fault,
  input wire logic i_resp_en,
  input wire logic [FIELD_W-1:0] i_field,
  input wire logic [FIELD_W-1:0] i_mode_pin_resp,
  output logic o_hic,
  output logic o_latch
);
  logic [FIELD_W-1:0] code;

  always_comb begin
    // mode pin takes over every source while the global enable is low
    code = i_resp_en ? i_field : i_mode_pin_resp;
    // codes 00 and 11 fall through to flag only
    o_hic = i_fault && (code == rfr_pkg::RESP_HICCUP);
    o_latch = i_fault && (code == rfr_pkg::RESP_LATCH);
  end
endmodule : rfr_src_decode

// ----------------------------------------------------------------
// sticky status next value
// ----------------------------------------------------------------
module rfr_sticky_next #(
  parameter int W = 8
) (
  input wire logic [W-1:0] i_q,
  input wire logic i_clr_en,
  input wire logic [W-1:0] i_clr_mask,
  input wire logic [W-1:0] i_set,
  output logic [W-1:0] o_d
);
  logic [W-1:0] kept;

  always_comb begin
    kept = i_clr_en ? (i_q & ~i_clr_mask) : i_q;
    // set wins over a clear in the same cycle, so no event is lost
    o_d = kept | i_set;
  end
endmodule : rfr_sticky_next

//--- test/rfr_sva.sv
// checker for the rail fault response select block
module rfr_sva #(parameter int HICCUP_CYCLES = 20) (
  input wire logic i_core_clk, input wire logic i_rst_b, input wire logic i_resp_en,
  input wire logic [1:0] i_mode_pin_resp, input wire logic i_driver_rail_ov,
  input wire logic i_driver_rail_uv, input wire logic i_core_rail_ov,
  input wire logic i_core_rail_uv, input wire logic i_pwm_en, input wire logic i_chip_en,
  input wire logic o_pwm_stop, input wire logic o_fault_flag_n_oe
);
  wire logic [3:0] flt = {i_core_rail_uv, i_core_rail_ov, i_driver_rail_uv, i_driver_rail_ov};
  wire logic pin = !i_resp_en && ^i_mode_pin_resp;
  wire logic hic = pin && i_mode_pin_resp[0];
  int unsigned run_q;
  // a restart timer that never expires overruns this count
  always_ff @(posedge i_core_clk or negedge i_rst_b)
    if (!i_rst_b) run_q <= 32'h0;
    else run_q <= (o_pwm_stop && flt == 4'h0 && hic) ? run_q + 32'h1 : 32'h0;
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_b);
  property p_flag; |flt |=> o_fault_flag_n_oe; endproperty
  a_flag: assert property (p_flag) else $error("no flag");
  property p_both; $rose(o_pwm_stop) |-> o_fault_flag_n_oe; endproperty
  a_both: assert property (p_both) else $error("stop without flag");
  property p_stop; pin && |flt |=> o_pwm_stop; endproperty
  a_stop: assert property (p_stop) else $error("no stop");
  property p_keep; !i_resp_en && !pin && !o_pwm_stop |=> !o_pwm_stop; endproperty
  a_keep: assert property (p_keep) else $error("flag mode stop");
  property p_cause; $rose(o_pwm_stop) |-> $past(flt) != 4'h0; endproperty
  a_cause: assert property (p_cause) else $error("stop without fault");
  property p_hic; hic && $fell(flt != 4'h0) |-> o_pwm_stop [*8]; endproperty
  a_hic: assert property (p_hic) else $error("early restart");
  property p_hlen; run_q <= HICCUP_CYCLES + 3; endproperty
  a_hlen: assert property (p_hlen) else $error("late restart");
  property p_latch; pin && !hic && o_pwm_stop && i_pwm_en && i_chip_en |=> o_pwm_stop;
  endproperty
  a_latch: assert property (p_latch) else $error("latch lost");
  property p_free; pin && !hic && !i_pwm_en && flt == 4'h0 |-> ##[1:2] !o_pwm_stop;
  endproperty
  a_free: assert property (p_free) else $error("latch stuck");
  c_hic: cover property (hic && $fell(o_pwm_stop));
  c_lat: cover property (pin && !hic && $fell(o_pwm_stop));
  c_clr: cover property ($fell(o_fault_flag_n_oe));
endmodule : rfr_sva
bind rfr_top rfr_sva #(.HICCUP_CYCLES(HICCUP_CYCLES)) sva_u (.*);

//--- test/rfr_host.sv
// far side enables: switching enable drops three cycles on request
module rfr_host (
  input wire logic i_core_clk,
  input wire logic i_rst_b,
  input wire logic i_toggle,
  output logic o_pwm_en
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] low_q;
  assign o_pwm_en = (low_q == 2'h0);
  always_ff @(posedge i_core_clk or negedge i_rst_b)
    if (!i_rst_b) low_q <= 2'h0;
    else low_q <= i_toggle ? 2'h3 : low_q - 2'(low_q != 2'h0);
endmodule : rfr_host

//--- test/rfr_top_bench.sv
// self-checking bench for the rail fault response select block
module rfr_top_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0, rst_b = 1'b0, wr = 1'b0, en = 1'b0, tog = 1'b0, ce = 1'b1;
  logic [7:0] a = 8'h00, d = 8'h00, q;
  logic [1:0] mode = 2'h0, src, code;
  logic [3:0] flt = 4'h0;
  logic pe, stop, fo, oe;
  int st[4] = '{2, 3, 0, 1};
  int errors = 0, compares = 0;
  always #5 clk = ~clk;
  rfr_top #(.HICCUP_CYCLES(20)) dut_u (.i_core_clk(clk), .i_rst_b(rst_b), .i_reg_wr(wr),
    .i_reg_addr(a), .i_reg_wdata(d), .o_reg_rdata(q), .i_resp_en(en), .i_mode_pin_resp(mode),
    .i_driver_rail_ov(flt[0]), .i_driver_rail_uv(flt[1]), .i_core_rail_ov(flt[2]),
    .i_core_rail_uv(flt[3]), .i_pwm_en(pe), .i_chip_en(ce), .o_pwm_stop(stop),
    .o_fault_flag_n_out(fo), .o_fault_flag_n_oe(oe));
  rfr_host host_u (.i_core_clk(clk), .i_rst_b(rst_b), .i_toggle(tog), .o_pwm_en(pe));
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    compares++;
    if (g !== e) begin
      errors++;
      $display("BAD %0t got %h want %h", $time, g, e);
    end
  endtask : chk
  task automatic rd(input logic [7:0] ad, input logic [7:0] e);
    @(posedge clk);
    a <= ad;
    @(posedge clk);
    #1 chk(q, e);
  endtask : rd
  task automatic wrr(input logic [7:0] ad, input logic [7:0] v);
    @(posedge clk);
    wr <= 1'b1;
    a <= ad;
    d <= v;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wrr
  task automatic results();
    if (errors == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : results
  initial begin
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    rd(8'hB3, 8'h00);
    wrr(8'hB3, 8'hE4);
    rd(8'hB3, 8'hE4);
    rd(8'hB5, 8'h00);
    // each code once through the fields, then the mode pin overriding them
    for (int k = 0; k < 7; k++) begin
      src = (k < 4) ? 2'(k) : 2'h0;
      code = (k < 4) ? 2'(k) : 2'(k - 3);
      @(posedge clk);
      en <= (k < 4);
      mode <= (k < 4) ? {1'b0, ~^code} : code;
      flt <= 4'h1 << src;
      repeat (3) @(posedge clk);
      #1 chk(8'({fo, oe, stop}), 8'({2'b01, ^code}));
      @(posedge clk);
      flt <= 4'h0;
      repeat (10) @(posedge clk);
      #1 chk(8'(stop), 8'(^code));
      @(posedge clk);
      tog <= (code == 2'h2) && (k < 4);
      ce <= !((code == 2'h2) && (k >= 4));
      @(posedge clk);
      tog <= 1'b0;
      ce <= 1'b1;
      for (int n = 0; stop !== 1'b0; n++) begin
        if (n > 60) begin
          errors++;
          results();
        end
        @(posedge clk);
      end
      rd(8'hD3, 8'h01 << st[src]);
      wrr(8'hD3, 8'hFF);
      repeat (2) @(posedge clk);
      #1 chk(8'(oe), 8'h00);
    end
    results();
  end
endmodule : rfr_top_bench
